// file: rtl/host_frame_mailbox_port.sv
// host access port: indirect window, frame queues, command buffers, irqs
// Function
// - write-only index at offset 0 holds 16-bit indirect register address
// - 8-bit read/write data port at offset 2 reaches the indirect register
// - 16-bit frame port at offset 3 carries switch frames both ways
// - frames start with an 8-byte header; data padded to eight bytes
// - 8-bit register at offset 4: writes are commands, reads are status
// - command bit 0 marks receive buffer loaded; clears by itself
// - command bits 1, 2 release transmit buffers 1, 2; self-clearing
// - command bit 3 ends transmit frame, rest discarded, self-clearing
// - command bit 4 marks next receive queue write as frame end
// - command bit 5 realigns receive stream; bits 7:6 kept zero
// - status bit 0 is one while receive buffer accepts a command
// - status bits 1, 2 are one while transmit buffers hold a frame
// - status bits 3, 4, 5: tx data, rx room, tx frame end
// - interrupt register at offset 5, bit 0 frame event, 6:3 reserved
// - interrupt bits 1, 2 flag transmit buffers holding data
// - interrupt bit 7 timeout stays set until written with zero
// - offset 6 writes receive buffer, reads transmit buffer 1
// - offset 7 is read-only and reads next word of buffer 2
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module host_frame_mailbox_port #(
  parameter int CBUF_DEPTH = host_mbox_pkg::CBUF_DEPTH_DEF
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire host_mbox_pkg::host_req_s host_req,
  output logic [15:0] host_rdata,
  output host_mbox_pkg::ind_bus_s ind_bus,
  input wire logic [7:0] ind_rdata,
  input wire host_mbox_pkg::txq_in_s txq_in,
  output logic txq_pop,
  output logic txq_done,
  output host_mbox_pkg::rxq_out_s rxq_out,
  input wire logic rxq_room,
  input wire logic cmdrx_rd,
  output logic [15:0] cmdrx_data,
  output logic cmdrx_valid,
  output logic cmdrx_ready,
  input wire logic cmdrx_done,
  input wire logic [1:0] cmdtx_wr,
  input wire logic [15:0] cmdtx_wdata,
  input wire logic [1:0] cmdtx_commit,
  input wire logic dev_timeout,
  output logic irq
);

  typedef struct packed {
    logic [15:0] rdata;
    host_mbox_pkg::ind_bus_s ind;
    host_mbox_pkg::rxq_out_s rxq;
    logic txq_pop;
    logic txq_done;
    logic flushing;
    logic tx_eof_seen;
    logic eof_armed;
    logic [2:0] hdr_cnt;
    logic txq_valid_d;
    logic [1:0] txb_full_d;
    logic rxb_commit;
    logic [1:0] txb_drop;
    logic [15:0] cmdrx_data;
    logic cmdrx_valid;
    logic [7:0] irq_mask;
    logic irq;
  } port_state_s;

  port_state_s st_r;
  port_state_s st_nxt;

  logic host_wr;
  logic host_rd;
  logic [3:0] host_addr;
  logic [15:0] wd;
  logic rxb_full;
  logic [15:0] rxb_head;
  logic [1:0] txb_full;
  logic [15:0] txb_head [2];
  logic [1:0] txb_rd;
  logic [7:0] irq_stat;
  logic [7:0] irq_set;

  assign host_wr = host_req.wr;
  assign host_rd = host_req.rd;
  assign host_addr = host_req.addr;
  assign wd = host_req.wdata;

  // receive command buffer: cpu fills it, switch drains it
  cmd_frame_buffer #(
    .WIDTH(16),
    .DEPTH(CBUF_DEPTH)
  ) u_rx_buf (
    .core_clk(core_clk),
    .resetn(resetn),
    .wr_en(host_wr && host_addr == host_mbox_pkg::OFS_CBUF1),
    .wr_data(wd),
    .commit(st_r.rxb_commit),
    .rd_en(cmdrx_rd),
    .drop(cmdrx_done),
    .head(rxb_head),
    .full(rxb_full)
  );

  assign txb_rd[0] = host_rd && host_addr == host_mbox_pkg::OFS_CBUF1;
  assign txb_rd[1] = host_rd && host_addr == host_mbox_pkg::OFS_CBUF2;

  // transmit command buffers: switch fills them, cpu drains them
  for (genvar i = 0; i < 2; i++) begin : g_txb
    cmd_frame_buffer #(
      .WIDTH(16),
      .DEPTH(CBUF_DEPTH)
    ) u_tx_buf (
      .core_clk(core_clk),
      .resetn(resetn),
      .wr_en(cmdtx_wr[i]),
      .wr_data(cmdtx_wdata),
      .commit(cmdtx_commit[i]),
      .rd_en(txb_rd[i]),
      .drop(st_r.txb_drop[i]),
      .head(txb_head[i]),
      .full(txb_full[i])
    );
  end

  always_comb begin
    irq_set = '0;
    irq_set[host_mbox_pkg::IRQ_FRAME] =
      txq_in.valid && !st_r.txq_valid_d;
    irq_set[host_mbox_pkg::IRQ_CBUF1] =
      txb_full[0] && !st_r.txb_full_d[0];
    irq_set[host_mbox_pkg::IRQ_CBUF2] =
      txb_full[1] && !st_r.txb_full_d[1];
    irq_set[host_mbox_pkg::IRQ_TIMEOUT] = dev_timeout;
  end

  sticky_event_bank #(
    .W(8),
    .W1C_BITS(host_mbox_pkg::IRQ_W1C_BITS),
    .W0C_BITS(host_mbox_pkg::IRQ_W0C_BITS),
    .USED_BITS(host_mbox_pkg::IRQ_USED_BITS)
  ) u_irq_bank (
    .core_clk(core_clk),
    .resetn(resetn),
    .set(irq_set),
    .clr_wr(host_wr && host_addr == host_mbox_pkg::OFS_IRQ),
    .clr_data(wd[7:0]),
    .status(irq_stat)
  );

  always_comb begin
    logic [7:0] stat_byte;
    stat_byte = '0;
    st_nxt = st_r;
    // pulses and read data last exactly one cycle
    st_nxt.rdata = '0;
    st_nxt.ind.wr = 1'b0;
    st_nxt.ind.rd = 1'b0;
    st_nxt.rxq.push = 1'b0;
    st_nxt.rxq.realign = 1'b0;
    st_nxt.txq_pop = 1'b0;
    st_nxt.txq_done = 1'b0;
    st_nxt.rxb_commit = 1'b0;
    st_nxt.txb_drop = '0;
    st_nxt.cmdrx_valid = 1'b0;
    st_nxt.txq_valid_d = txq_in.valid;
    st_nxt.txb_full_d = txb_full;
    st_nxt.irq = |(irq_stat & st_r.irq_mask);

    stat_byte[host_mbox_pkg::ST_RXBUF_FREE] = !rxb_full;
    stat_byte[host_mbox_pkg::ST_TXBUF1_FULL] = txb_full[0];
    stat_byte[host_mbox_pkg::ST_TXBUF2_FULL] = txb_full[1];
    stat_byte[host_mbox_pkg::ST_TXQ_HAS_DATA] = txq_in.valid;
    stat_byte[host_mbox_pkg::ST_RXQ_HAS_ROOM] = rxq_room;
    stat_byte[host_mbox_pkg::ST_TXQ_FRAME_END] = txq_in.eof;

    // discard the rest of a transmit frame; one pop per two cycles
    // because the queue head moves only after the pop pulse
    if (st_r.flushing && txq_in.valid && !st_r.txq_pop) begin
      st_nxt.txq_pop = 1'b1;
      if (txq_in.eof) begin
        st_nxt.flushing = 1'b0;
      end
    end

    if (cmdrx_rd && rxb_full) begin
      st_nxt.cmdrx_data = rxb_head;
      st_nxt.cmdrx_valid = 1'b1;
    end

    if (host_wr) begin
      case (host_addr)
        host_mbox_pkg::OFS_INDEX: begin
          st_nxt.ind.addr = wd;
        end
        host_mbox_pkg::OFS_IND_DATA: begin
          st_nxt.ind.wdata = wd[7:0];
          st_nxt.ind.wr = 1'b1;
        end
        host_mbox_pkg::OFS_FRAME: begin
          if (rxq_room) begin
            st_nxt.rxq.push = 1'b1;
            st_nxt.rxq.data = wd;
            st_nxt.rxq.eof = st_r.eof_armed;
            st_nxt.rxq.hdr = st_r.hdr_cnt < host_mbox_pkg::HDR_WORDS;
            st_nxt.eof_armed = 1'b0;
            if (st_r.eof_armed) begin
              st_nxt.hdr_cnt = '0;
            end else if (st_r.hdr_cnt < host_mbox_pkg::HDR_WORDS) begin
              st_nxt.hdr_cnt = st_r.hdr_cnt + 3'h1;
            end
          end
        end
        host_mbox_pkg::OFS_CMD_STAT: begin
          st_nxt.rxb_commit = wd[host_mbox_pkg::CMD_RXBUF_READY];
          st_nxt.txb_drop[0] = wd[host_mbox_pkg::CMD_TXBUF1_DONE];
          st_nxt.txb_drop[1] = wd[host_mbox_pkg::CMD_TXBUF2_DONE];
          if (wd[host_mbox_pkg::CMD_TXQ_DONE]) begin
            st_nxt.txq_done = 1'b1;
            st_nxt.flushing = !st_r.tx_eof_seen;
            st_nxt.tx_eof_seen = 1'b0;
          end
          if (wd[host_mbox_pkg::CMD_RXQ_EOF]) begin
            st_nxt.eof_armed = 1'b1;
          end
          // realign restarts header counting and forgets a pending end
          if (wd[host_mbox_pkg::CMD_REALIGN]) begin
            st_nxt.rxq.realign = 1'b1;
            st_nxt.hdr_cnt = '0;
            st_nxt.eof_armed = 1'b0;
          end
        end
        host_mbox_pkg::OFS_IRQ_MASK: begin
          st_nxt.irq_mask = wd[7:0];
        end
        default: begin
        end
      endcase
    end

    if (host_rd) begin
      case (host_addr)
        host_mbox_pkg::OFS_IND_DATA: begin
          st_nxt.rdata = {8'h00, ind_rdata};
          st_nxt.ind.rd = 1'b1;
        end
        host_mbox_pkg::OFS_FRAME: begin
          if (txq_in.valid && !st_r.txq_pop && !st_r.flushing) begin
            st_nxt.rdata = txq_in.data;
            st_nxt.txq_pop = 1'b1;
            if (txq_in.eof) begin
              st_nxt.tx_eof_seen = 1'b1;
            end
          end
        end
        host_mbox_pkg::OFS_CMD_STAT: begin
          st_nxt.rdata = {8'h00, stat_byte};
        end
        host_mbox_pkg::OFS_IRQ: begin
          st_nxt.rdata = {8'h00, irq_stat};
        end
        host_mbox_pkg::OFS_CBUF1: begin
          if (txb_full[0]) begin
            st_nxt.rdata = txb_head[0];
          end
        end
        host_mbox_pkg::OFS_CBUF2: begin
          if (txb_full[1]) begin
            st_nxt.rdata = txb_head[1];
          end
        end
        host_mbox_pkg::OFS_IRQ_MASK: begin
          st_nxt.rdata = {8'h00, st_r.irq_mask};
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.ind.addr <= host_mbox_pkg::INDEX_RESET;
      st_r.irq_mask <= host_mbox_pkg::MASK_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign host_rdata = st_r.rdata;
  assign ind_bus = st_r.ind;
  assign txq_pop = st_r.txq_pop;
  assign txq_done = st_r.txq_done;
  assign rxq_out = st_r.rxq;
  assign cmdrx_data = st_r.cmdrx_data;
  assign cmdrx_valid = st_r.cmdrx_valid;
  assign cmdrx_ready = rxb_full;
  assign irq = st_r.irq;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // pulse checks allow a back-to-back strobe to raise the pulse again
  index_track_a: assert property (
    host_wr && host_addr == host_mbox_pkg::OFS_INDEX
    |=> ind_bus.addr == $past(wd)) else $error("index not loaded");
  ind_write_a: assert property (
    host_wr && host_addr == host_mbox_pkg::OFS_IND_DATA
    |=> ind_bus.wr && ind_bus.wdata == $past(wd[7:0]) &&
        ind_bus.addr == $past(ind_bus.addr) ##1 (!ind_bus.wr ||
        $past(host_wr && host_addr == host_mbox_pkg::OFS_IND_DATA)))
    else $error("indirect write wrong");
  ind_read_a: assert property (
    host_rd && host_addr == host_mbox_pkg::OFS_IND_DATA
    |=> host_rdata == {8'h00, $past(ind_rdata)} && ind_bus.rd)
    else $error("indirect read data wrong");
  frame_read_a: assert property (
    host_rd && host_addr == host_mbox_pkg::OFS_FRAME && txq_in.valid &&
    !txq_pop && !st_r.flushing
    |=> txq_pop && host_rdata == $past(txq_in.data) ##1 !txq_pop)
    else $error("frame port read wrong");
  frame_write_a: assert property (
    host_wr && host_addr == host_mbox_pkg::OFS_FRAME && rxq_room &&
    st_r.hdr_cnt == 3'h0 && !st_r.eof_armed
    |=> rxq_out.push && rxq_out.hdr && rxq_out.data == $past(wd))
    else $error("frame word not pushed as header");
  rxbuf_ready_a: assert property (
    host_wr && host_addr == host_mbox_pkg::OFS_CMD_STAT &&
    wd[host_mbox_pkg::CMD_RXBUF_READY] && !cmdrx_done
    |=> st_r.rxb_commit ##1 (rxb_full || $past(cmdrx_done)) &&
        (!st_r.rxb_commit ||
        $past(host_wr && wd[host_mbox_pkg::CMD_RXBUF_READY])))
    else $error("receive buffer commit wrong");
  txbuf_drop_a: assert property (
    host_wr && host_addr == host_mbox_pkg::OFS_CMD_STAT &&
    wd[host_mbox_pkg::CMD_TXBUF1_DONE]
    |=> ##1 !txb_full[0] || $past(cmdtx_commit[0]))
    else $error("transmit buffer 1 not released");
  txq_done_a: assert property (
    host_wr && host_addr == host_mbox_pkg::OFS_CMD_STAT &&
    wd[host_mbox_pkg::CMD_TXQ_DONE]
    |=> txq_done ##1 (!txq_done ||
        $past(host_wr && wd[host_mbox_pkg::CMD_TXQ_DONE])))
    else $error("done pulse wrong");
  eof_mark_a: assert property (
    st_r.eof_armed && host_wr && host_addr == host_mbox_pkg::OFS_FRAME &&
    rxq_room |=> rxq_out.push && rxq_out.eof && !st_r.eof_armed)
    else $error("frame end not marked");
  realign_a: assert property (
    host_wr && host_addr == host_mbox_pkg::OFS_CMD_STAT &&
    wd[host_mbox_pkg::CMD_REALIGN]
    |=> rxq_out.realign && st_r.hdr_cnt == 3'h0 ##1 (!rxq_out.realign ||
        $past(host_wr && wd[host_mbox_pkg::CMD_REALIGN])))
    else $error("realign wrong");
  status_read_a: assert property (
    host_rd && host_addr == host_mbox_pkg::OFS_CMD_STAT
    |=> host_rdata[host_mbox_pkg::ST_TXQ_HAS_DATA] == $past(txq_in.valid) &&
        host_rdata[host_mbox_pkg::ST_RXQ_HAS_ROOM] == $past(rxq_room) &&
        host_rdata[host_mbox_pkg::ST_RXBUF_FREE] == !$past(rxb_full) &&
        host_rdata[15:6] == 10'h000) else $error("status byte wrong");
  frame_irq_a: assert property (
    txq_in.valid && !st_r.txq_valid_d |=> irq_stat[host_mbox_pkg::IRQ_FRAME])
    else $error("frame event not latched");
  cbuf_irq_a: assert property (
    txb_full[1] && !st_r.txb_full_d[1] |=> irq_stat[host_mbox_pkg::IRQ_CBUF2])
    else $error("buffer 2 event not latched");
  timeout_hold_a: assert property (
    irq_stat[host_mbox_pkg::IRQ_TIMEOUT] &&
    !(host_wr && host_addr == host_mbox_pkg::OFS_IRQ && !wd[7])
    |=> irq_stat[host_mbox_pkg::IRQ_TIMEOUT]) else $error("timeout lost");
  cbuf_read_a: assert property (
    host_rd && host_addr == host_mbox_pkg::OFS_CBUF2 && txb_full[1]
    |=> host_rdata == $past(txb_head[1])) else $error("buffer 2 read wrong");

endmodule : host_frame_mailbox_port

// file: rtl/host_mbox_pkg.sv
// shared offsets, field positions, reset values and carriers of the host port
package host_mbox_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register offsets (word index on the host port)
  localparam logic [3:0] OFS_INDEX = 4'h0;
  localparam logic [3:0] OFS_IND_DATA = 4'h2;
  localparam logic [3:0] OFS_FRAME = 4'h3;
  localparam logic [3:0] OFS_CMD_STAT = 4'h4;
  localparam logic [3:0] OFS_IRQ = 4'h5;
  localparam logic [3:0] OFS_CBUF1 = 4'h6;
  localparam logic [3:0] OFS_CBUF2 = 4'h7;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h8;

  // command bits, written
  localparam int CMD_RXBUF_READY = 0;
  localparam int CMD_TXBUF1_DONE = 1;
  localparam int CMD_TXBUF2_DONE = 2;
  localparam int CMD_TXQ_DONE = 3;
  localparam int CMD_RXQ_EOF = 4;
  localparam int CMD_REALIGN = 5;

  // status bits, read
  localparam int ST_RXBUF_FREE = 0;
  localparam int ST_TXBUF1_FULL = 1;
  localparam int ST_TXBUF2_FULL = 2;
  localparam int ST_TXQ_HAS_DATA = 3;
  localparam int ST_RXQ_HAS_ROOM = 4;
  localparam int ST_TXQ_FRAME_END = 5;

  // interrupt source bits
  localparam int IRQ_FRAME = 0;
  localparam int IRQ_CBUF1 = 1;
  localparam int IRQ_CBUF2 = 2;
  localparam int IRQ_TIMEOUT = 7;
  localparam logic [7:0] IRQ_W1C_BITS = 8'h07;
  localparam logic [7:0] IRQ_W0C_BITS = 8'h80;
  localparam logic [7:0] IRQ_USED_BITS = 8'h87;

  // 8-byte frame header is four 16-bit words
  localparam logic [2:0] HDR_WORDS = 3'h4;

  localparam logic [15:0] INDEX_RESET = 16'h0000;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int CBUF_DEPTH_DEF = 32;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } host_req_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ind_bus_s;

  typedef struct packed {
    logic [15:0] data;
    logic valid;
    logic eof;
  } txq_in_s;

  typedef struct packed {
    logic [15:0] data;
    logic push;
    logic eof;
    logic hdr;
    logic realign;
  } rxq_out_s;

endpackage : host_mbox_pkg

// file: rtl/cmd_frame_buffer.sv
// one control command frame buffer: fill, commit, drain, drop
`timescale 1ns/1ps
module cmd_frame_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic commit,
  input wire logic rd_en,
  input wire logic drop,
  output logic [WIDTH-1:0] head,
  output logic full
);
  localparam int PW = $clog2(DEPTH) + 1;

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic full;
  } buf_state_s;

  buf_state_s st_r;
  buf_state_s st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic wr_ok;

  // writes while full or past the end are dropped, not wrapped
  assign wr_ok = wr_en && !st_r.full && (st_r.wr_ptr < PW'(DEPTH));

  always_comb begin
    st_nxt = st_r;
    if (wr_ok) begin
      st_nxt.wr_ptr = st_r.wr_ptr + PW'(1);
    end
    // reader parks on the last word instead of running into stale data
    if (rd_en && st_r.full && (st_r.rd_ptr + PW'(1) < st_r.wr_ptr)) begin
      st_nxt.rd_ptr = st_r.rd_ptr + PW'(1);
    end
    if (commit && !st_r.full) begin
      st_nxt.full = 1'b1;
      st_nxt.rd_ptr = '0;
    end
    if (drop) begin
      st_nxt.full = 1'b0;
      st_nxt.wr_ptr = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_ok) begin
      mem[st_r.wr_ptr[PW-2:0]] <= wr_data;
    end
  end

  assign head = mem[st_r.rd_ptr[PW-2:0]];
  assign full = st_r.full;

  buf_commit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    commit && !drop |=> full) else $error("commit did not mark buffer full");

endmodule : cmd_frame_buffer

// file: rtl/sticky_event_bank.sv
// sticky event bits with per-bit write-one or write-zero clearing
`timescale 1ns/1ps
module sticky_event_bank #(
  parameter int W = 8,
  parameter logic [W-1:0] W1C_BITS = '0,
  parameter logic [W-1:0] W0C_BITS = '0,
  parameter logic [W-1:0] USED_BITS = '1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [W-1:0] set,
  input wire logic clr_wr,
  input wire logic [W-1:0] clr_data,
  output logic [W-1:0] status
);
  logic [W-1:0] stat_r;
  logic [W-1:0] stat_nxt;

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic clr;
    assign clr = clr_wr && ((W1C_BITS[i] && clr_data[i]) ||
                            (W0C_BITS[i] && !clr_data[i]));
    // a set in the clearing cycle wins so no event is lost
    assign stat_nxt[i] = USED_BITS[i] && (set[i] || (stat_r[i] && !clr));
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  assign status = stat_r;

endmodule : sticky_event_bank

// file: verification/switch_side_model.sv
// far-side model: indirect register file and switch-to-cpu frame queue
`timescale 1ns/1ps
module switch_side_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire host_mbox_pkg::ind_bus_s ind_bus,
  output logic [7:0] ind_rdata,
  input wire logic txq_en,
  input wire logic txq_pop,
  output host_mbox_pkg::txq_in_s txq_in
);
  logic [7:0] regs_r [256];
  logic [15:0] cnt_r;

  // combinational, as the port expects within the same clock
  assign ind_rdata = regs_r[ind_bus.addr[7:0]];
  assign txq_in.data = cnt_r;
  assign txq_in.valid = txq_en;
  // header plus padded data: eight words a frame
  assign txq_in.eof = (cnt_r[2:0] == 3'h7);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnt_r <= 16'h0000;
    end else if (txq_pop) begin
      cnt_r <= cnt_r + 16'h0001;
    end
    if (ind_bus.wr) begin
      regs_r[ind_bus.addr[7:0]] <= ind_bus.wdata;
    end
  end
endmodule : switch_side_model

// file: verification/tb_top.sv
// self-checking bench of the host frame mailbox port
`timescale 1ns/1ps
module tb_top;
  logic core_clk, resetn, rxq_room, cmdrx_rd, cmdrx_done, dev_timeout;
  logic txq_en, txq_pop, txq_done, irq, cmdrx_valid, cmdrx_ready;
  logic [15:0] host_rdata, cmdrx_data, cmdtx_wdata, v;
  logic [7:0] ind_rdata;
  logic [1:0] cmdtx_wr, cmdtx_commit;
  host_mbox_pkg::host_req_s host_req;
  host_mbox_pkg::ind_bus_s ind_bus;
  host_mbox_pkg::txq_in_s txq_in;
  host_mbox_pkg::rxq_out_s rxq_out;
  int fails, num_checks;
  logic [31:0] seed;
  logic [15:0] idx [4];
  logic [7:0] dat [4];

  host_frame_mailbox_port uut (.core_clk(core_clk), .resetn(resetn),
    .host_req(host_req), .host_rdata(host_rdata), .ind_bus(ind_bus),
    .ind_rdata(ind_rdata), .txq_in(txq_in), .txq_pop(txq_pop),
    .txq_done(txq_done), .rxq_out(rxq_out), .rxq_room(rxq_room),
    .cmdrx_rd(cmdrx_rd), .cmdrx_data(cmdrx_data),
    .cmdrx_valid(cmdrx_valid), .cmdrx_ready(cmdrx_ready),
    .cmdrx_done(cmdrx_done), .cmdtx_wr(cmdtx_wr),
    .cmdtx_wdata(cmdtx_wdata), .cmdtx_commit(cmdtx_commit),
    .dev_timeout(dev_timeout), .irq(irq));

  switch_side_model far (.core_clk(core_clk), .resetn(resetn),
    .ind_bus(ind_bus), .ind_rdata(ind_rdata), .txq_en(txq_en),
    .txq_pop(txq_pop), .txq_in(txq_in));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  // expected status read: free, full1, full2, tx data, rx room, tx end
  function automatic logic [15:0] st(input logic [5:0] b);
    return {10'h000, b[0], b[1], b[2], b[3], b[4], b[5]};
  endfunction : st

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    host_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    host_req.wr <= 1'b0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    host_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    host_req.rd <= 1'b0;
    #1 d = host_rdata;
  endtask : rd

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // whole run is well under a thousand cycles
  initial begin
    #100000;
    fails++;
    $display("[ERR] t=%0t watchdog expired", $time);
    finish_test;
  end

  initial begin
    {resetn, rxq_room, cmdrx_rd, cmdrx_done, dev_timeout, txq_en} = '0;
    {cmdtx_wr, cmdtx_commit, cmdtx_wdata} = '0;
    host_req = '0;
    seed = 32'h1ada;
    fails = 0;
    num_checks = 0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rxq_room <= 1'b1;
    @(posedge core_clk);
    #1 chk({15'h0000, cmdrx_ready}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      idx[i] = {seed[15:8], 8'(i)};
      dat[i] = seed[23:16];
      wr(host_mbox_pkg::OFS_INDEX, idx[i]);
      chk(ind_bus.addr, idx[i]);
      wr(host_mbox_pkg::OFS_IND_DATA, {8'h00, dat[i]});
      chk({7'h00, ind_bus.wr, ind_bus.wdata}, {8'h01, dat[i]});
    end
    for (int i = 0; i < 4; i++) begin
      wr(host_mbox_pkg::OFS_INDEX, idx[i]);
      rd(host_mbox_pkg::OFS_IND_DATA, v);
      chk(v, {8'h00, dat[i]});
    end
    $display("test indirect done");
    @(posedge core_clk) txq_en <= 1'b1;
    rd(host_mbox_pkg::OFS_CMD_STAT, v);
    chk(v, st(6'b100110));
    rd(host_mbox_pkg::OFS_IRQ, v);
    chk(v, 16'h0001);
    for (int h = 0; h < 2; h++) begin
      rd(host_mbox_pkg::OFS_FRAME, v);
      chk(v, 16'(h));
    end
    wr(host_mbox_pkg::OFS_CMD_STAT, 16'h0008);
    chk({15'h0000, txq_done}, 16'h0001);
    // rest of the frame is dropped; next read starts the next frame
    repeat (20) @(posedge core_clk);
    rd(host_mbox_pkg::OFS_FRAME, v);
    chk(v, 16'h0008);
    wr(host_mbox_pkg::OFS_IRQ, 16'h0001);
    rd(host_mbox_pkg::OFS_IRQ, v);
    chk(v, 16'h0000);
    $display("test frame read done");
    for (int i = 0; i < 6; i++) begin
      if (i == 4) wr(host_mbox_pkg::OFS_CMD_STAT, 16'h0010);
      seed = xs(seed);
      wr(host_mbox_pkg::OFS_FRAME, seed[15:0]);
      chk(rxq_out.data, seed[15:0]);
      chk({rxq_out.push, rxq_out.hdr, rxq_out.eof},
          {1'b1, 1'(i < 4 || i == 5), 1'(i == 4)});
    end
    wr(host_mbox_pkg::OFS_CMD_STAT, 16'h0020);
    chk({15'h0000, rxq_out.realign}, 16'h0001);
    $display("test frame write done");
    seed = xs(seed);
    wr(host_mbox_pkg::OFS_CBUF1, seed[15:0]);
    wr(host_mbox_pkg::OFS_CMD_STAT, 16'h0001);
    repeat (2) @(posedge core_clk);
    #1 chk({15'h0000, cmdrx_ready}, 16'h0001);
    rd(host_mbox_pkg::OFS_CMD_STAT, v);
    chk(v & 16'h0001, 16'h0000);
    @(posedge core_clk) cmdrx_rd <= 1'b1;
    @(posedge core_clk) cmdrx_rd <= 1'b0;
    #1 chk(cmdrx_data, seed[15:0]);
    chk({15'h0000, cmdrx_valid}, 16'h0001);
    @(posedge core_clk) cmdrx_done <= 1'b1;
    @(posedge core_clk) cmdrx_done <= 1'b0;
    rd(host_mbox_pkg::OFS_CMD_STAT, v);
    chk(v & 16'h0001, 16'h0001);
    $display("test receive buffer done");
    for (int b = 0; b < 2; b++) begin
      seed = xs(seed);
      @(posedge core_clk);
      cmdtx_wr <= 2'(1 << b);
      cmdtx_wdata <= seed[15:0];
      @(posedge core_clk);
      cmdtx_wr <= 2'h0;
      cmdtx_commit <= 2'(1 << b);
      @(posedge core_clk) cmdtx_commit <= 2'h0;
      rd(host_mbox_pkg::OFS_CMD_STAT, v);
      chk(v & 16'h0006, 16'(2 << b));
      rd(host_mbox_pkg::OFS_IRQ, v);
      chk(v & 16'h0006, 16'(2 << b));
      wr(host_mbox_pkg::OFS_IRQ, 16'(2 << b));
      rd(4'(host_mbox_pkg::OFS_CBUF1 + 4'(b)), v);
      chk(v, seed[15:0]);
      wr(host_mbox_pkg::OFS_CMD_STAT, 16'(2 << b));
      rd(host_mbox_pkg::OFS_CMD_STAT, v);
      chk(v & 16'h0006, 16'h0000);
    end
    $display("test transmit buffers done");
    wr(host_mbox_pkg::OFS_IRQ_MASK, 16'h0080);
    @(posedge core_clk) dev_timeout <= 1'b1;
    @(posedge core_clk) dev_timeout <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk({15'h0000, irq}, 16'h0001);
    // writing a one must not clear the timeout bit
    wr(host_mbox_pkg::OFS_IRQ, 16'h0080);
    rd(host_mbox_pkg::OFS_IRQ, v);
    chk(v, 16'h0080);
    wr(host_mbox_pkg::OFS_IRQ, 16'h0000);
    rd(host_mbox_pkg::OFS_IRQ, v);
    chk(v, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    $display("test timeout done");
    finish_test;
  end
endmodule : tb_top
